/* logic/hvif_pkg.sv */
/*
 * Constants for the indirect high-voltage register interface: register
 * addresses, field positions, command codes and link timing.
 * Assumes a 50 MHz system clock and a separate serial link clock.
 */
package hvif_pkg;
    localparam logic [31:0] HVIF_CMD_ADDR   = 32'hffff0804;
    localparam logic [31:0] HVIF_DAT_ADDR   = 32'hffff080c;
    localparam logic [7:0]  HVIF_CMD_RST    = 8'h00;
    localparam logic [11:0] HVIF_DAT_RST    = 12'h000;

    localparam int HVIF_BUSY_BIT  = 0;
    localparam int HVIF_RDOK_BIT  = 1;
    localparam int HVIF_WROK_BIT  = 2;
    localparam int HVIF_TAG_LSB   = 8;

    localparam logic [7:0] HVIF_RD_CFG0 = 8'h00;
    localparam logic [7:0] HVIF_RD_CFG1 = 8'h01;
    localparam logic [7:0] HVIF_RD_STA  = 8'h02;
    localparam logic [7:0] HVIF_RD_MON  = 8'h03;
    localparam logic [7:0] HVIF_WR_CFG0 = 8'h08;
    localparam logic [7:0] HVIF_WR_CFG1 = 8'h09;

    // Link frame: 4 command bits, 8 data bits, then one ack bit
    localparam int HVIF_CMD_BITS   = 4;
    localparam int HVIF_FRAME_BITS = 13;
    localparam int HVIF_LINK_KHZ   = 2560;
    localparam int HVIF_MAX_LAT_US = 10;
    localparam int HVIF_SYS_MHZ    = 50;
    localparam int HVIF_TIMEOUT_CYC = HVIF_MAX_LAT_US * HVIF_SYS_MHZ;
endpackage : hvif_pkg

/* logic/hvif_core.sv */
/*
 * Indirect high-voltage register interface: command/status and data
 * registers on the processor bus, serial link to the high-voltage die.
 * Assumes a simple synchronous register port on clk_sys and a link clock
 * (lnk_clk, 2.56 MHz) that runs free; the far die samples lnk_dat_out
 * on rising lnk_clk and drives lnk_dat_in for the ack and read byte.
 */
`timescale 1ns/1ns
// Behaviour
// - Command register decodes read/write commands
// - 0x00/0x01 fetch config zero/one
// - 0x02/0x03 fetch status/monitor
// - 0x08/0x09 send data to config
// - Bit 0 reads busy until done
// - Bit 2 reports write outcome
// - Bit 1 reports read outcome
// - Success flags valid only when not busy
// - Twelve-bit data register resets zero
// - Data bits 7-0 hold byte
// - Bits 11-8 read-only command tag
// - Two-wire serial link at 2.56MHz
// - Transfers finish within ten microseconds
// - Indirect registers reachable only via link
module hvif_core #(
    parameter int FRAME_BITS = hvif_pkg::HVIF_FRAME_BITS,
    parameter int TMO_CYC    = hvif_pkg::HVIF_TIMEOUT_CYC
) (
    input  wire logic                clk_sys,
    input  wire logic                rst,
    input  wire logic                lnk_clk,
    input  wire logic [31:0]         reg_addr,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    input  wire logic [31:0]         reg_wdata,
    output logic      [31:0]         reg_rdata,
    output logic                     lnk_dat_out,
    output logic                     lnk_dat_oe,
    input  wire logic                lnk_dat_in,
    output logic                     lnk_clk_en
);
    import hvif_pkg::*;

    // The frame is laid out as nibble, byte, ack and cannot stretch
    if (FRAME_BITS != HVIF_CMD_BITS + 8 + 1) begin : g_frame_chk
        $error("hvif_core: FRAME_BITS must equal 13");
    end
    // The watchdog counter is ten bits wide
    if (TMO_CYC < 2 || TMO_CYC > 1023) begin : g_tmo_chk
        $error("hvif_core: TMO_CYC must lie in 2..1023");
    end
    // Both registers decode from one address compare each
    if (HVIF_CMD_ADDR == HVIF_DAT_ADDR) begin : g_addr_chk
        $error("hvif_core: register addresses must differ");
    end

    typedef enum logic [2:0] {
        HVIF_IDLE = 3'b001,
        HVIF_WAIT = 3'b010,
        HVIF_DONE = 3'b100
    } hvif_state_t;

    function automatic logic cmd_valid(input logic [7:0] c);
        cmd_valid = (c == HVIF_RD_CFG0) || (c == HVIF_RD_CFG1) ||
                    (c == HVIF_RD_STA)  || (c == HVIF_RD_MON)  ||
                    (c == HVIF_WR_CFG0) || (c == HVIF_WR_CFG1);
    endfunction : cmd_valid

    function automatic logic tmo_hit(input logic [9:0] t);
        tmo_hit = (t == 10'(TMO_CYC - 1));
    endfunction : tmo_hit

    // Bit positions of a frame that carry the returned byte
    function automatic logic rx_bit(input logic [3:0] b);
        rx_bit = (b >= 4'(HVIF_CMD_BITS)) && (b < 4'(FRAME_BITS - 1));
    endfunction : rx_bit

    hvif_state_t state_ff;
    logic [7:0]  cmd_ff;
    logic [7:0]  dat_ff;
    logic [3:0]  tag_ff;
    logic        rdok_ff;
    logic        wrok_ff;
    logic [9:0]  tmo_ff;
    logic        req_tgl_ff;
    logic        sys_wr_cmd;
    logic        sys_wr_dat;
    logic        cmd_take;
    logic        wait_end;
    logic        busy;

    // Software view of the two registers
    logic        rd_ok_shown;
    logic        wr_ok_shown;
    logic [7:0]  cmd_view;
    logic [11:0] dat_view;

    // Link side signals
    logic [1:0]  lreq_sync_ff;
    logic        lreq_seen_ff;
    logic [3:0]  lbit_ff;
    logic [11:0] lsh_ff;
    logic [7:0]  lrx_ff;
    logic        lack_ff;
    logic        ldone_tgl_ff;
    logic        lbusy_ff;
    logic        lstart;
    logic        llast;
    logic [11:0] frame_word;
    logic [2:0]  done_sync_ff;
    logic        done_evt;

    assign sys_wr_cmd = reg_wr && (reg_addr == HVIF_CMD_ADDR);
    assign sys_wr_dat = reg_wr && (reg_addr == HVIF_DAT_ADDR);
    assign done_evt   = done_sync_ff[2] ^ done_sync_ff[1];
    assign busy       = (state_ff != HVIF_IDLE);

    // Undefined codes are dropped here and never reach the link
    assign cmd_take = !busy && sys_wr_cmd &&
                      cmd_valid(reg_wdata[7:0]);
    // Timeout bounds latency if the die never answers
    assign wait_end = (state_ff == HVIF_WAIT) &&
                      (done_evt || tmo_hit(tmo_ff));

    // Flags are hidden while busy: they belong to the last command
    assign rd_ok_shown = !busy && rdok_ff;
    assign wr_ok_shown = !busy && wrok_ff;

    // Busy sequencing: idle, waiting on the link, one cycle of done
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_ff <= HVIF_IDLE;
        end else begin
            case (state_ff)
                HVIF_IDLE: begin
                    if (cmd_take) begin
                        state_ff <= HVIF_WAIT;
                    end
                end
                HVIF_WAIT: begin
                    if (wait_end) begin
                        state_ff <= HVIF_DONE;
                    end
                end
                HVIF_DONE: begin
                    state_ff <= HVIF_IDLE;
                end
                default: begin
                    state_ff <= HVIF_IDLE;
                end
            endcase
        end
    end

    // Command code; the link side reads it while the frame runs
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cmd_ff <= HVIF_CMD_RST;
        end else if (cmd_take) begin
            cmd_ff <= reg_wdata[7:0];
        end
    end

    // One toggle per accepted command crosses to the link domain
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            req_tgl_ff <= 1'b0;
        end else if (cmd_take) begin
            req_tgl_ff <= ~req_tgl_ff;
        end
    end

    // Watchdog on the die's answer
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tmo_ff <= '0;
        end else if (cmd_take) begin
            tmo_ff <= '0;
        end else if (state_ff == HVIF_WAIT) begin
            tmo_ff <= tmo_ff + 10'd1;
        end
    end

    // Read outcome; a timeout counts as a failure
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdok_ff <= 1'b0;
        end else if (wait_end && !cmd_ff[3]) begin
            rdok_ff <= done_evt && lack_ff;
        end
    end

    // Write outcome; a timeout counts as a failure
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wrok_ff <= 1'b0;
        end else if (wait_end && cmd_ff[3]) begin
            wrok_ff <= done_evt && lack_ff;
        end
    end

    // Data byte: software writes are refused while busy
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dat_ff <= HVIF_DAT_RST[7:0];
        end else if (wait_end && done_evt &&
                     !cmd_ff[3] && lack_ff) begin
            dat_ff <= lrx_ff;
        end else if (sys_wr_dat && !busy) begin
            dat_ff <= reg_wdata[7:0];
        end
    end

    // Tag is never written by software; a failed read leaves it alone
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tag_ff <= HVIF_DAT_RST[11:8];
        end else if (wait_end && done_evt &&
                     !cmd_ff[3] && lack_ff) begin
            tag_ff <= cmd_ff[3:0];
        end
    end

    // Status byte as software sees it; reserved bits read as zero
    always_comb begin
        cmd_view = '0;
        cmd_view[HVIF_BUSY_BIT] = busy;
        cmd_view[HVIF_RDOK_BIT] = rd_ok_shown;
        cmd_view[HVIF_WROK_BIT] = wr_ok_shown;
    end

    assign dat_view = {tag_ff, dat_ff};

    // Read mux; unmapped reads and idle cycles return zero
    always_comb begin
        reg_rdata = '0;
        if (reg_rd && reg_addr == HVIF_CMD_ADDR) begin
            reg_rdata[7:0] = cmd_view;
        end else if (reg_rd && reg_addr == HVIF_DAT_ADDR) begin
            reg_rdata[11:0] = dat_view;
        end
    end

    // Completion toggle comes back from the link domain
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            done_sync_ff <= '0;
        end else begin
            done_sync_ff <= {done_sync_ff[1:0], ldone_tgl_ff};
        end
    end

    // Link domain. cmd_ff and dat_ff are stable while a request is
    // outstanding, so they are read here without a second crossing.
    always_ff @(posedge lnk_clk) begin
        if (rst) begin
            lreq_sync_ff <= '0;
        end else begin
            lreq_sync_ff <= {lreq_sync_ff[0], req_tgl_ff};
        end
    end

    assign lstart = !lbusy_ff &&
                    (lreq_sync_ff[1] != lreq_seen_ff);
    assign llast  = lbusy_ff && (lbit_ff == 4'(FRAME_BITS - 1));
    // Nibble first, then the byte, both MSB first
    assign frame_word = {cmd_ff[3:0], dat_ff};

    // Last request toggle taken up by the link
    always_ff @(posedge lnk_clk) begin
        if (rst) begin
            lreq_seen_ff <= 1'b0;
        end else if (lstart) begin
            lreq_seen_ff <= lreq_sync_ff[1];
        end
    end

    // Frame in progress; also gates the link clock at the pin
    always_ff @(posedge lnk_clk) begin
        if (rst) begin
            lbusy_ff <= 1'b0;
        end else if (lstart) begin
            lbusy_ff <= 1'b1;
        end else if (llast) begin
            lbusy_ff <= 1'b0;
        end
    end

    // Bit counter; it is reloaded at every frame start, so the
    // value it is left with after the ack bit does not matter
    always_ff @(posedge lnk_clk) begin
        if (rst) begin
            lbit_ff <= '0;
        end else if (lstart) begin
            lbit_ff <= '0;
        end else if (lbusy_ff) begin
            lbit_ff <= lbit_ff + 4'd1;
        end
    end

    // Outgoing shifter
    always_ff @(posedge lnk_clk) begin
        if (rst) begin
            lsh_ff <= '0;
        end else if (lstart) begin
            lsh_ff <= frame_word;
        end else if (lbusy_ff && !llast) begin
            lsh_ff <= {lsh_ff[10:0], 1'b0};
        end
    end

    // The die answers on falling lnk_clk from this same clock, so the
    // line is sampled here directly; a synchroniser would cost the
    // die two bits it cannot know in advance
    always_ff @(posedge lnk_clk) begin
        if (rst) begin
            lrx_ff <= '0;
        end else if (lbusy_ff && rx_bit(lbit_ff)) begin
            lrx_ff <= {lrx_ff[6:0], lnk_dat_in};
        end
    end

    // Ack is the last bit of every frame
    always_ff @(posedge lnk_clk) begin
        if (rst) begin
            lack_ff <= 1'b0;
        end else if (llast) begin
            lack_ff <= lnk_dat_in;
        end
    end

    // Completion toggle back to the system domain
    always_ff @(posedge lnk_clk) begin
        if (rst) begin
            ldone_tgl_ff <= 1'b0;
        end else if (llast) begin
            ldone_tgl_ff <= ~ldone_tgl_ff;
        end
    end

    assign lnk_dat_out = lsh_ff[11];
    assign lnk_dat_oe  = lbusy_ff &&
                         (lbit_ff < 4'(HVIF_CMD_BITS) || cmd_ff[3]);
    assign lnk_clk_en  = lbusy_ff;
endmodule : hvif_core

/* test/hvif_monitor.sv */
/* Port checker for hvif_core.
   Bound to every hvif_core; all checks sample on clk_sys. */
`timescale 1ns/1ns
module hvif_monitor
    import hvif_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        lnk_clk,
    input wire logic [31:0] reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        lnk_dat_oe,
    input wire logic        lnk_clk_en
);
    logic rc;
    logic rd;
    assign rc = reg_rd && reg_addr == HVIF_CMD_ADDR;
    assign rd = reg_rd && reg_addr == HVIF_DAT_ADDR;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_idle; rc && !reg_rdata[0] && !reg_wr; endsequence
    sequence s_start; $rose(lnk_clk_en); endsequence
    property p_quiet; !reg_rd |-> reg_rdata == 32'h0; endproperty
    a_quiet: assert property (p_quiet) else $error("rdata idle");
    property p_unmap; reg_rd && !rc && !rd |-> reg_rdata == 0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped");
    property p_cmdw; rc |-> reg_rdata[31:3] == 0; endproperty
    a_cmdw: assert property (p_cmdw) else $error("cmd width");
    property p_datw; rd |-> reg_rdata[31:12] == 0; endproperty
    a_datw: assert property (p_datw) else $error("data width");
    property p_flag; rc && reg_rdata[0] |-> reg_rdata[2:1] == 0; endproperty
    a_flag: assert property (p_flag) else $error("flags busy");
    property p_stay; s_idle ##1 rc |-> !reg_rdata[0]; endproperty
    a_stay: assert property (p_stay) else $error("busy no cmd");
    property p_oe; lnk_dat_oe |-> lnk_clk_en; endproperty
    a_oe: assert property (p_oe) else $error("drive off frame");
    property p_frame; s_start |-> ##[8:14] !lnk_clk_en; endproperty
    a_frame: assert property (p_frame) else $error("frame len");
endmodule : hvif_monitor
bind hvif_core hvif_monitor hvif_monitor_i (.clk_sys, .rst, .lnk_clk,
    .reg_addr, .reg_wr, .reg_rd, .reg_rdata, .lnk_dat_oe, .lnk_clk_en);

/* test/hvif_die_model.sv */
/* Far die: four 8-bit registers behind the link.
   Assumes 4 command bits, 8 data bits, then an ack bit. */
`timescale 1ns/1ns
module hvif_die_model #(
    parameter logic [7:0] STA_VAL = 8'h5a,
    parameter logic [7:0] MON_VAL = 8'hc3
) (
    input  wire logic lnk_clk,
    input  wire logic rst,
    input  wire logic lnk_clk_en,
    input  wire logic lnk_dat_out,
    input  wire logic nack,
    output logic      lnk_dat_in
);
    logic [3:0]  cnt_ff;
    logic [3:0]  nib_ff;
    logic [10:0] sh_ff;
    logic [7:0]  cfg_ff [2];
    logic [7:0]  rb;
    // Registers exist only here
    assign rb = nib_ff[1] ? (nib_ff[0] ? MON_VAL : STA_VAL) : cfg_ff[nib_ff[0]];
    always_ff @(posedge lnk_clk) begin
        if (rst || !lnk_clk_en) begin
            cnt_ff <= 4'h0;
        end else begin
            cnt_ff <= cnt_ff + 4'h1;
            sh_ff <= {sh_ff[9:0], lnk_dat_out};
            if (cnt_ff == 4'h3) nib_ff <= {sh_ff[2:0], lnk_dat_out};
            // A refused frame leaves the register alone
            if (cnt_ff == 4'hb && !nack && nib_ff[3])
                cfg_ff[nib_ff[0]] <= {sh_ff[6:0], lnk_dat_out};
        end
        if (rst) cfg_ff <= '{8'h00, 8'h00};
    end
    initial lnk_dat_in = 1'b0;
    // Byte MSB first, then ack; a released line toggles
    always @(negedge lnk_clk)
        if (lnk_clk_en && cnt_ff >= 4'h4 && cnt_ff <= 4'hb)
            lnk_dat_in <= rb[4'hb - cnt_ff];
        else if (lnk_clk_en && cnt_ff == 4'hc) lnk_dat_in <= !nack;
        else lnk_dat_in <= !lnk_dat_in;
endmodule : hvif_die_model

/* test/tb.sv */
/* Self-checking bench for hvif_core.
   Assumes the die model on the link and the bound checker. */
`timescale 1ns/1ns
module tb;
    import hvif_pkg::*;
    logic        clk_sys, rst, lnk_clk, reg_wr, reg_rd, nack;
    logic        lnk_dat_out, lnk_dat_oe, lnk_dat_in, lnk_clk_en;
    logic [31:0] reg_addr, reg_wdata, reg_rdata, v;
    logic [11:0] e;
    logic [7:0]  c, sh [2];
    logic [2:0]  f;
    int          num_errors, checks, seed, i, k;
    hvif_core hvif_core_i (.clk_sys, .rst, .lnk_clk, .reg_addr, .reg_wr,
        .reg_rd, .reg_wdata, .reg_rdata, .lnk_dat_out, .lnk_dat_oe,
        .lnk_dat_in, .lnk_clk_en);
    hvif_die_model hvif_die_model_i (.lnk_clk, .rst, .lnk_clk_en,
        .lnk_dat_out, .nack, .lnk_dat_in);
    function automatic logic [7:0] rdv(logic [7:0] x);
        return x[1] ? (x[0] ? 8'hc3 : 8'h5a) : sh[x[0]];
    endfunction : rdv
    task automatic chk(input logic [31:0] got, exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [31:0] a, d);
        @(negedge clk_sys);
        reg_wr = w;
        reg_rd = !w;
        reg_addr = a;
        reg_wdata = d;
        #2 v = reg_rdata;
    endtask : acc
    task automatic poll;
        for (k = 0; k < 1000 && v[0] !== 1'b0; k++)
            acc(0, HVIF_CMD_ADDR, 0);
        if (v[0] !== 1'b0) begin
            num_errors++;
            test_done;
        end
    endtask : poll
    task test_done;
        $display("errors=%0d checks=%0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : test_done
    initial begin
        clk_sys = 0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial begin
        lnk_clk = 0;
        forever begin
            #7 lnk_clk = 1;
            #8 lnk_clk = 0;
        end
    end
    initial begin
        seed = 32'h6051;
        {reg_wr, reg_rd, nack, reg_addr, reg_wdata} = '0;
        {num_errors, checks, e, f} = '0;
        sh = '{8'h00, 8'h00};
        rst = 1;
        repeat (10) @(negedge clk_sys);
        rst = 0;
        acc(0, HVIF_CMD_ADDR, 0);
        chk(v, {24'h0, HVIF_CMD_RST});
        acc(0, HVIF_DAT_ADDR, 0);
        chk(v, {20'h0, HVIF_DAT_RST});
        acc(0, 32'hffff0808, 0);
        chk(v, 0);
        for (i = 0; i < 14; i++) begin
            c = i == 13 ? 8'h05 : 8'(i % 6 < 4 ? i % 6 : i % 6 + 4);
            nack = i == 7 || i == 10;
            e[7:0] = 8'($random(seed));
            acc(1, HVIF_DAT_ADDR, {24'h0, e[7:0]});
            acc(1, HVIF_CMD_ADDR, {24'h0, c});
            acc(0, HVIF_CMD_ADDR, 0);
            chk(v[0], c != 8'h05);
            poll;
            if (c < 8'h04 && !nack) e = {c[3:0], rdv(c)};
            if (c[3] && !nack) sh[c[0]] = e[7:0];
            // Each flag keeps its value until a command of its kind ends
            if (c != 8'h05 && c[3]) f[2] = !nack;
            if (c != 8'h05 && !c[3]) f[1] = !nack;
            chk(v, {29'h0, f});
            acc(0, HVIF_DAT_ADDR, 0);
            chk(v, {20'h0, e});
        end
        test_done;
    end
endmodule : tb
